// >>> bench/eacc_chk.sv
// Assertion checker for the accumulation configuration block.
`timescale 1ns/1ns
`default_nettype none
module eacc_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic signed [23:0] active_power,
	input wire logic signed [23:0] reactive_power,
	input wire logic power_valid,
	input wire logic accum_term_valid,
	input wire logic signed [23:0] active_accum_term,
	input wire logic signed [23:0] reactive_accum_term,
	input wire logic [2:0] voltage_gain_code,
	input wire logic [2:0] current_gain_code,
	input wire logic voltage_input_ground,
	input wire logic current_input_ground
);
	// ========
	// Shadow copies of the accumulation mode, gain and calibration registers.
	logic [7:0] md_ff, gn_ff, cl_ff;
	wire logic wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{md_ff, gn_ff, cl_ff} <= '0;
		end else if (wr_ok) begin
			if (avs_address == eacc_pkg::ADDR_ACCUM_MODE) md_ff <= avs_writedata[7:0];
			if (avs_address == eacc_pkg::ADDR_GAIN) gn_ff <= avs_writedata[7:0];
			if (avs_address == eacc_pkg::ADDR_CAL_MODE) cl_ff <= avs_writedata[7:0];
		end
	end
	function automatic logic signed [23:0] mag(input logic signed [23:0] v);
		return v < 0 ? -v : v;
	endfunction
	function automatic logic [2:0] clp(input logic [2:0] c);
		return c > 3'h4 ? 3'h4 : c;
	endfunction
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_gain_wr;
		wr_ok && avs_address == eacc_pkg::ADDR_GAIN;
	endsequence
	sequence s_cal_wr;
		wr_ok && avs_address == eacc_pkg::ADDR_CAL_MODE;
	endsequence
	a_volt_gain: assert property (s_gain_wr |-> ##[1:2] voltage_gain_code == clp(gn_ff[7:5]))
		else $error("voltage gain code wrong");
	a_curr_gain: assert property (s_gain_wr |-> ##[1:2] current_gain_code == clp(gn_ff[2:0]))
		else $error("current gain code wrong");
	a_volt_ground: assert property (s_cal_wr |-> ##[1:2] voltage_input_ground == cl_ff[3])
		else $error("voltage ground wrong");
	a_curr_ground: assert property (s_cal_wr |-> ##[1:2] current_input_ground == cl_ff[2])
		else $error("current ground wrong");
	a_abs_active: assert property (power_valid && md_ff[0] |=> active_accum_term == mag($past(active_power)))
		else $error("absolute active term wrong");
	a_pos_active: assert property (power_valid && md_ff[1:0] == 2'h2 |=>
		active_accum_term == ($past(active_power[23]) ? 24'h0 : $past(active_power)))
		else $error("positive active term wrong");
	a_abs_react: assert property (power_valid && md_ff[3] |=> reactive_accum_term == mag($past(reactive_power)))
		else $error("absolute reactive term wrong");
	a_signed_react: assert property (power_valid && md_ff[3:2] == 2'h1 |=>
		reactive_accum_term == ($past(active_power[23]) ? -$past(reactive_power) : $past(reactive_power)))
		else $error("signed reactive term wrong");
	a_term_valid: assert property (accum_term_valid == $past(power_valid))
		else $error("term valid timing wrong");
endmodule // eacc_chk
bind eacc_config eacc_chk i_chk (.sys_clk, .rst, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
	.avs_waitrequest, .active_power, .reactive_power, .power_valid, .accum_term_valid, .active_accum_term,
	.reactive_accum_term,
	.voltage_gain_code, .current_gain_code, .voltage_input_ground, .current_input_ground);
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench for the accumulation configuration block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, power_valid = 1'b0;
	logic fault_mode = 1'b0, tamper_use_b = 1'b0, avs_waitrequest, accum_term_valid, current_input_b_sel;
	logic voltage_input_ground, current_input_ground, sign_irq_pending;
	logic energy_pulse_active = 1'b0, energy_pulse_reactive = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic signed [23:0] active_power = 24'h0, reactive_power = 24'h0, active_accum_term, reactive_accum_term;
	logic [2:0] voltage_gain_code, current_gain_code;
	int errors = 0, checks = 0, cyc = 0;
	eacc_config i_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
		.avs_readdata, .avs_waitrequest, .active_power, .reactive_power, .power_valid, .energy_pulse_active,
		.energy_pulse_reactive, .fault_mode, .tamper_use_b, .active_accum_term, .reactive_accum_term,
		.accum_term_valid, .voltage_gain_code, .current_gain_code, .current_input_b_sel, .voltage_input_ground,
		.current_input_ground, .sign_irq_pending);
	// ========
	// Clock, timeout and shared tasks.
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			test_done();
		end
	end
	task test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !w;
		avs_write <= w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input string nm, input logic [7:0] a, e);
		logic [31:0] q;
		bus(1'b0, a, 8'h0, q);
		chk(nm, q, {24'h0, e});
	endtask
	task samp(input logic signed [23:0] a, r);
		active_power <= a;
		reactive_power <= r;
		power_valid <= 1'b1;
		@(posedge sys_clk);
		power_valid <= 1'b0;
		@(posedge sys_clk);
	endtask
	// ========
	// Scenarios.
	task test_reset;
		rd("mode", eacc_pkg::ADDR_ACCUM_MODE, 8'h00);
		rd("gain", eacc_pkg::ADDR_GAIN, 8'h00);
		chk("voltage gain reset", voltage_gain_code, 3'h0);
		chk("current gain reset", current_gain_code, 3'h0);
		rd("cal", eacc_pkg::ADDR_CAL_MODE, 8'h00);
		rd("unmapped", 8'h22, 8'h00);
		$display("test reset done");
	endtask
	task test_gain;
		for (int c = 1; c < 8; c++) begin
			wr(eacc_pkg::ADDR_GAIN, {c[2:0], 2'h0, c[2:0]});
			chk("voltage gain", voltage_gain_code, c > 4 ? 4 : c);
			chk("current gain", current_gain_code, c > 4 ? 4 : c);
		end
		wr(eacc_pkg::ADDR_GAIN, 8'hff);
		rd("gain", eacc_pkg::ADDR_GAIN, 8'hef);
		wr(eacc_pkg::ADDR_GAIN, 8'h01);
		$display("test gain done");
	endtask
	task test_chan;
		tamper_use_b <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			wr(eacc_pkg::ADDR_CAL_MODE, {2'h0, c[1:0], 4'h0});
			chk("input b", current_input_b_sel, c != 1);
			rd("channel", eacc_pkg::ADDR_ACCUM_MODE, {c != 1, 7'h0});
		end
		tamper_use_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("input auto", current_input_b_sel, 1'b0);
		for (int g = 0; g < 2; g++) begin
			wr(eacc_pkg::ADDR_CAL_MODE, 8'h08 >> g);
			chk("volt ground", voltage_input_ground, g == 0);
			chk("curr ground", current_input_ground, g == 1);
		end
		wr(eacc_pkg::ADDR_CAL_MODE, 8'h00);
		$display("test channel done");
	endtask
	task test_accum;
		logic [7:0] md [6] = '{8'h01, 8'h02, 8'h02, 8'h08, 8'h04, 8'h04};
		int ea [6] = '{5, 0, 5, -5, -5, 5};
		int er [6] = '{-7, -7, -7, 7, 7, -7};
		for (int i = 0; i < 6; i++) begin
			wr(eacc_pkg::ADDR_ACCUM_MODE, md[i]);
			samp((i == 2 || i == 5) ? 24'sd5 : -24'sd5, -24'sd7);
			chk("active term", active_accum_term, ea[i]);
			chk("reactive term", reactive_accum_term, er[i]);
		end
		$display("test accumulation done");
	endtask
	task test_sign;
		wr(eacc_pkg::ADDR_SIGN_ENABLE, 8'h07);
		wr(eacc_pkg::ADDR_ACCUM_MODE, 8'h00);
		samp(24'sd5, 24'sd7);
		wr(eacc_pkg::ADDR_SIGN_STATUS, 8'h07);
		rd("status idle", eacc_pkg::ADDR_SIGN_STATUS, 8'h00);
		fault_mode <= 1'b1;
		samp(-24'sd5, -24'sd7);
		rd("status falling", eacc_pkg::ADDR_SIGN_STATUS, 8'h07);
		chk("irq", sign_irq_pending, 1'b1);
		wr(eacc_pkg::ADDR_SIGN_STATUS, 8'h07);
		samp(-24'sd5, -24'sd7);
		rd("status repeat", eacc_pkg::ADDR_SIGN_STATUS, 8'h00);
		chk("irq clear", sign_irq_pending, 1'b0);
		wr(eacc_pkg::ADDR_ACCUM_MODE, 8'h70);
		fault_mode <= 1'b0;
		samp(24'sd5, 24'sd7);
		rd("status rising", eacc_pkg::ADDR_SIGN_STATUS, 8'h07);
		wr(eacc_pkg::ADDR_SIGN_ENABLE, 8'h00);
		chk("irq masked", sign_irq_pending, 1'b0);
		$display("test sign done");
	endtask
	task test_source;
		wr(eacc_pkg::ADDR_ACCUM_MODE, 8'h00);
		wr(eacc_pkg::ADDR_GAIN, 8'h09);
		wr(eacc_pkg::ADDR_SIGN_STATUS, 8'h07);
		samp(-24'sd5, -24'sd7);
		rd("status no pulse", eacc_pkg::ADDR_SIGN_STATUS, 8'h00);
		energy_pulse_active <= 1'b1;
		energy_pulse_reactive <= 1'b1;
		@(posedge sys_clk);
		energy_pulse_active <= 1'b0;
		energy_pulse_reactive <= 1'b0;
		@(posedge sys_clk);
		rd("status per pulse", eacc_pkg::ADDR_SIGN_STATUS, 8'h03);
		wr(eacc_pkg::ADDR_GAIN, 8'h01);
		$display("test sign source done");
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		test_reset();
		test_gain();
		test_chan();
		test_accum();
		test_sign();
		test_source();
		test_done();
	end
endmodule // tb_top
`default_nettype wire

// >>> hdl/eacc_config.sv
// Accumulation, gain and channel configuration registers with sign and fault event logic.
`timescale 1ns/1ns
`default_nettype none
module eacc_config (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic signed [23:0] active_power,
	input wire logic signed [23:0] reactive_power,
	input wire logic power_valid,
	input wire logic energy_pulse_active,
	input wire logic energy_pulse_reactive,
	input wire logic fault_mode,
	input wire logic tamper_use_b,
	output logic signed [23:0] active_accum_term,
	output logic signed [23:0] reactive_accum_term,
	output logic accum_term_valid,
	output logic [2:0] voltage_gain_code,
	output logic [2:0] current_gain_code,
	output logic current_input_b_sel,
	output logic voltage_input_ground,
	output logic current_input_ground,
	output logic sign_irq_pending
);
	typedef struct packed {
		eacc_pkg::eacc_bus_state_t bus;
		logic [7:0] accum_mode;
		logic [7:0] gain;
		logic [7:0] cal_mode;
		logic [7:0] sign_status;
		logic [7:0] sign_enable;
		logic [31:0] rdata;
		logic fault_prev;
		logic fault_primed;
		logic use_b;
		logic signed [23:0] act_term;
		logic signed [23:0] react_term;
		logic term_valid;
		logic irq;
	} eacc_state_t;

	eacc_state_t st_ff;
	eacc_state_t nxt_st;
	logic act_sample_valid;
	logic react_sample_valid;
	logic act_event;
	logic react_event;
	logic fault_event;
	logic [7:0] wr_byte;

	eacc_edge_if act_if();
	eacc_edge_if react_if();

	function automatic logic signed [23:0] neg24(input logic signed [23:0] v);
		neg24 = 24'(-v);
	endfunction

	function automatic logic [2:0] clamp_gain(input logic [2:0] code);
		clamp_gain = (code > eacc_pkg::GAIN_MAX_CODE) ? eacc_pkg::GAIN_MAX_CODE : code;
	endfunction

	// =====================================================
	// Sign detection sources
	// The filtered power is sampled each valid, or only on each output pulse. [R11]
	assign act_sample_valid = st_ff.gain[eacc_pkg::B_SIGN_SRC] ? energy_pulse_active : power_valid;
	assign react_sample_valid = st_ff.gain[eacc_pkg::B_SIGN_SRC] ? energy_pulse_reactive : power_valid;

	assign act_if.sample_valid = act_sample_valid;
	assign act_if.sample_neg = active_power[23];
	assign act_if.rise_select = st_ff.accum_mode[eacc_pkg::B_ACT_EDGE]; // [R4]
	assign react_if.sample_valid = react_sample_valid;
	assign react_if.sample_neg = reactive_power[23];
	assign react_if.rise_select = st_ff.accum_mode[eacc_pkg::B_REACT_EDGE]; // [R3]
	assign act_event = act_if.event_pulse;
	assign react_event = react_if.event_pulse;

	eacc_edge_det u_act_det (
		.sys_clk(sys_clk),
		.rst(rst),
		.edge_port(act_if.det)
	);

	eacc_edge_det u_react_det (
		.sys_clk(sys_clk),
		.rst(rst),
		.edge_port(react_if.det)
	);

	// Fault entry fires with polarity clear, return to normal with it set. [R2]
	assign fault_event = st_ff.fault_primed && (st_ff.fault_prev != fault_mode) &&
		(st_ff.accum_mode[eacc_pkg::B_FAULT_POL] ? !fault_mode : fault_mode);

	assign wr_byte = avs_byteenable[0] ? avs_writedata[7:0] : eacc_pkg::RESET_BYTE;

	// =====================================================
	// Next state
	always_comb begin
		logic [7:0] read_byte;
		logic [7:0] set_bits;
		logic [7:0] clr_bits;
		logic hit_write;
		read_byte = eacc_pkg::RESET_BYTE;
		set_bits = eacc_pkg::RESET_BYTE;
		clr_bits = eacc_pkg::RESET_BYTE;
		hit_write = 1'b0;
		nxt_st = st_ff;
		nxt_st.term_valid = power_valid;

		// Tamper indicator follows the channel actually in use. [R1] [R12]
		case (st_ff.cal_mode[5:4])
			eacc_pkg::SEL_FORCE_A: nxt_st.use_b = 1'b0;
			eacc_pkg::SEL_FORCE_B: nxt_st.use_b = 1'b1;
			default: nxt_st.use_b = tamper_use_b;
		endcase

		// Active accumulation term: absolute wins, then positive only. [R8] [R7]
		if (power_valid) begin
			if (st_ff.accum_mode[eacc_pkg::B_ACT_ABS]) begin
				nxt_st.act_term = active_power[23] ? neg24(active_power) : active_power; // [R8]
			end else if (st_ff.accum_mode[eacc_pkg::B_ACT_POS]) begin
				nxt_st.act_term = active_power[23] ? '0 : active_power; // [R7]
			end else begin
				nxt_st.act_term = active_power;
			end
			if (st_ff.accum_mode[eacc_pkg::B_REACT_ABS]) begin
				nxt_st.react_term = reactive_power[23] ? neg24(reactive_power) : reactive_power; // [R5]
			end else if (st_ff.accum_mode[eacc_pkg::B_REACT_SBA]) begin
				nxt_st.react_term = active_power[23] ? neg24(reactive_power) : reactive_power; // [R6]
			end else begin
				nxt_st.react_term = reactive_power;
			end
		end

		nxt_st.fault_prev = fault_mode;
		nxt_st.fault_primed = 1'b1;

		// Status flags: write one to clear, a new event wins over the clear. [R18]
		set_bits[eacc_pkg::ST_ACT] = act_event;
		set_bits[eacc_pkg::ST_REACT] = react_event;
		set_bits[eacc_pkg::ST_FAULT] = fault_event;

		case (st_ff.bus)
			eacc_pkg::EACC_IDLE: begin
				if (avs_write) begin
					nxt_st.bus = eacc_pkg::EACC_ANSWER;
				end else if (avs_read) begin
					case (avs_address)
						eacc_pkg::ADDR_ACCUM_MODE: read_byte = {st_ff.use_b, st_ff.accum_mode[6:0]}; // [R1]
						eacc_pkg::ADDR_GAIN: read_byte = st_ff.gain;
						eacc_pkg::ADDR_CAL_MODE: read_byte = st_ff.cal_mode;
						eacc_pkg::ADDR_SIGN_STATUS: read_byte = st_ff.sign_status;
						eacc_pkg::ADDR_SIGN_ENABLE: read_byte = st_ff.sign_enable;
						default: read_byte = eacc_pkg::RESET_BYTE;
					endcase
					nxt_st.rdata = {24'h000000, read_byte};
					nxt_st.bus = eacc_pkg::EACC_ANSWER;
				end
			end
			eacc_pkg::EACC_ANSWER: begin
				// A write lands only at the edge that completes its transfer.
				hit_write = avs_write;
				nxt_st.bus = eacc_pkg::EACC_IDLE;
			end
			default: nxt_st.bus = eacc_pkg::EACC_IDLE;
		endcase

		if (hit_write && avs_byteenable[0]) begin
			case (avs_address)
				eacc_pkg::ADDR_ACCUM_MODE: nxt_st.accum_mode = wr_byte & eacc_pkg::ACCUM_WMASK;
				eacc_pkg::ADDR_GAIN: nxt_st.gain = wr_byte & eacc_pkg::GAIN_WMASK;
				// Reserved bits are stored as written; software keeps them zero. [R15]
				eacc_pkg::ADDR_CAL_MODE: nxt_st.cal_mode = wr_byte & eacc_pkg::CAL_WMASK;
				eacc_pkg::ADDR_SIGN_STATUS: clr_bits = wr_byte & eacc_pkg::SIGN_MASK;
				eacc_pkg::ADDR_SIGN_ENABLE: nxt_st.sign_enable = wr_byte & eacc_pkg::SIGN_MASK;
				default: clr_bits = eacc_pkg::RESET_BYTE;
			endcase
		end
		nxt_st.sign_status = (st_ff.sign_status & ~clr_bits) | set_bits; // [R18]
		nxt_st.irq = |(nxt_st.sign_status & nxt_st.sign_enable); // [R19]
	end

	// =====================================================
	// Registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0; // [R17]
		end else begin
			st_ff <= nxt_st;
		end
	end

	// =====================================================
	// Outputs
	assign avs_waitrequest = (avs_read || avs_write) && (st_ff.bus != eacc_pkg::EACC_ANSWER);
	assign avs_readdata = st_ff.rdata;
	assign active_accum_term = st_ff.act_term;
	assign reactive_accum_term = st_ff.react_term;
	assign accum_term_valid = st_ff.term_valid;
	assign voltage_gain_code = clamp_gain(st_ff.gain[7:5]); // [R9]
	assign current_gain_code = clamp_gain(st_ff.gain[2:0]); // [R10]
	assign current_input_b_sel = st_ff.use_b; // [R12]
	assign voltage_input_ground = st_ff.cal_mode[eacc_pkg::B_V_GND]; // [R13]
	assign current_input_ground = st_ff.cal_mode[eacc_pkg::B_I_GND]; // [R14]
	assign sign_irq_pending = st_ff.irq; // [R19]
endmodule // eacc_config
`default_nettype wire

// >>> hdl/eacc_edge_det.sv
// Sign transition detector producing one event per qualifying change.
`timescale 1ns/1ns
`default_nettype none
module eacc_edge_det (
	input wire logic sys_clk,
	input wire logic rst,
	eacc_edge_if.det edge_port
);
	eacc_pkg::eacc_edge_t st_ff;
	eacc_pkg::eacc_edge_t nxt_st;
	logic hit;

	// =====================================================
	// Edge compare
	always_comb begin
		nxt_st = st_ff;
		hit = 1'b0;
		if (edge_port.sample_valid) begin
			// Rising select fires on negative to positive, else positive to negative. [R20]
			if (st_ff.primed && (st_ff.prev_sign != edge_port.sample_neg)) begin
				hit = edge_port.rise_select ? st_ff.prev_sign : edge_port.sample_neg;
			end
			nxt_st.prev_sign = edge_port.sample_neg;
			nxt_st.primed = 1'b1;
		end
	end

	assign edge_port.event_pulse = hit;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule // eacc_edge_det
`default_nettype wire

// >>> include/eacc_edge_if.sv
// Interface carrying one sign detector's sample, edge choice and event.
`timescale 1ns/1ns
`default_nettype none
interface eacc_edge_if;
	logic sample_valid;
	logic sample_neg;
	logic rise_select;
	logic event_pulse;
	modport det (input sample_valid, input sample_neg, input rise_select, output event_pulse);
	modport src (output sample_valid, output sample_neg, output rise_select, input event_pulse);
endinterface : eacc_edge_if
`default_nettype wire

// >>> include/eacc_pkg.sv
// Package with the register map, field positions and shared types of the accumulation configuration block.
//
// Summary of operation
// R1 - Mode bit 7 reports tamper-selected current input.
// R2 - Bit 6 picks fault entry or exit event.
// R3 - Bit 5 picks reactive sign event edge.
// R4 - Bit 4 picks active sign event edge.
// R5 - Bit 3 accumulates absolute reactive power.
// R6 - Bit 2 signs reactive power by active sign.
// R7 - Bit 1 accumulates only positive active power.
// R8 - Bit 0 accumulates absolute active power.
// R9 - Gain bits 7:5 set voltage gain.
// R10 - Gain bits 2:0 set current gain.
// R11 - Gain bit 3 picks sign detection source.
// R12 - Calibration bits 5:4 choose current input.
// R13 - Calibration bit 3 grounds voltage input.
// R14 - Calibration bit 2 grounds current input.
// R15 - Software writes zero to calibration reserved bits.
// R16 - Software avoids current gain one.
// R17 - Mode and gain registers reset to zero.
// R18 - Selected sign change sets sign status flag.
// R19 - Enabled set flag raises pending interrupt.
// R20 - Successive sign samples give one event per selected sign change.
package eacc_pkg;
	localparam int ACC_W = 24;
	localparam logic [7:0] ADDR_ACCUM_MODE = 8'h0f;
	localparam logic [7:0] ADDR_GAIN = 8'h1b;
	localparam logic [7:0] ADDR_CAL_MODE = 8'h3d;
	localparam logic [7:0] ADDR_SIGN_STATUS = 8'h40;
	localparam logic [7:0] ADDR_SIGN_ENABLE = 8'h41;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int B_TAMPER_IND = 7;
	localparam int B_FAULT_POL = 6;
	localparam int B_REACT_EDGE = 5;
	localparam int B_ACT_EDGE = 4;
	localparam int B_REACT_ABS = 3;
	localparam int B_REACT_SBA = 2;
	localparam int B_ACT_POS = 1;
	localparam int B_ACT_ABS = 0;
	localparam int B_SIGN_SRC = 3;
	localparam int B_V_GND = 3;
	localparam int B_I_GND = 2;
	localparam int ST_FAULT = 2;
	localparam int ST_REACT = 1;
	localparam int ST_ACT = 0;
	localparam logic [7:0] ACCUM_WMASK = 8'h7f;
	localparam logic [7:0] GAIN_WMASK = 8'hef;
	localparam logic [7:0] CAL_WMASK = 8'hff;
	localparam logic [7:0] SIGN_MASK = 8'h07;
	localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
	localparam logic [1:0] SEL_FORCE_A = 2'h1;
	localparam logic [1:0] SEL_FORCE_B = 2'h2;
	typedef enum logic [1:0] {EACC_IDLE, EACC_ANSWER} eacc_bus_state_t;
	typedef struct packed {
		logic prev_sign;
		logic primed;
	} eacc_edge_t;
endpackage : eacc_pkg
